//--- verilog/hcf_flags.sv
// Purpose: host command mailbox flags, status build and attention
// Assumes: host write pins are asynchronous; other inputs are local
// Notes:   command routines and line protocol live outside
`timescale 1ns/100ps
`default_nettype none
module hcf_flags
   import hcf_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk_in,
   input  wire logic        rst_in,
   // adapter configuration
   input  wire logic        mode_sel_in,
   input  wire logic        alt_proto_in,
   // host i/o bus pins
   input  wire hcf_hostwr_s host_wr_in,
   output logic [7:0]       host_flags_out,
   output logic             host_lock_out,
   // line side
   input  wire logic [7:0]  line_main_status_word_in,
   input  wire logic [7:0]  line_control_word_in,
   input  wire logic        rx_handler_exit_in,
   output logic             online_req_out,
   // screen buffer read port
   output logic [15:0]      scr_addr_out,
   input  wire logic [7:0]  scr_data_in,
   // command engine
   input  wire logic        cmd_done_in,
   input  wire logic        cmd_clr_main_in,
   input  wire logic [7:0]  cmd_clr_bits_in,
   input  wire logic        cmd_trig_dm_we_in,
   input  wire logic        cmd_trig_addr_we_in,
   input  wire logic        cmd_attn_mask_we_in,
   input  wire logic [15:0] cmd_arg_in,
   output logic             cmd_pending_out,
   // status and core control
   output hcf_status_s      status_out,
   output logic             core_control_reg_pend_n_out,
   output logic             task_run_out
);

   // ***********************************************************
   // host pin capture
   // ***********************************************************
   hcf_hostwr_s wr_sync;      // synchronised host write group
   logic        stb_d_r;      // delayed strobe for edge detect
   logic        wr_rise;      // host write seen this cycle
   logic        in_block;     // address inside sixteen-byte block

   hcf_sync #(.W($bits(hcf_hostwr_s))) u_sync (
      .ref_clk_in (ref_clk_in),
      .rst_in     (rst_in),
      .d_in       (host_wr_in),
      .q_out      (wr_sync)
   );

   // edge detect reads only the second synchroniser stage
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         stb_d_r <= 1'b0;
      end else begin
         stb_d_r <= wr_sync.stb;
      end
   end

   assign in_block = (wr_sync.addr[9:4] == BLK_BASE);
   assign wr_rise  = wr_sync.stb & ~stb_d_r & in_block;

   // ***********************************************************
   // mode control
   // ***********************************************************
   hcf_mode_e mode_r;          // emulation mode state
   logic      mode_ok;         // configuration selects this mode
   logic      init_now;        // one-cycle initialisation
   logic      irq_en_r;        // host write event unmasked

   assign mode_ok  = mode_sel_in & ~alt_proto_in;
   assign init_now = (mode_r == HCF_INIT);

   // mode entry runs init once; leaving the mode drops to off
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         mode_r <= HCF_OFF;
      end else begin
         case (mode_r)
            HCF_OFF:  if (mode_ok) mode_r <= HCF_INIT;
            HCF_INIT: mode_r <= HCF_RUN;
            HCF_RUN:  if (!mode_ok) mode_r <= HCF_OFF;
            default:  mode_r <= HCF_OFF;
         endcase
      end
   end

   // init unmasks the event, schedules the task, asks for online
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         irq_en_r       <= 1'b0;
         task_run_out   <= 1'b0;
         online_req_out <= 1'b0;
      end else begin
         online_req_out <= init_now;
         if (init_now) begin
            irq_en_r     <= 1'b1;
            task_run_out <= 1'b1;
         end else if (mode_r == HCF_OFF) begin
            irq_en_r     <= 1'b0;
            task_run_out <= 1'b0;
         end
      end
   end

   // ***********************************************************
   // write event, lockout and service
   // ***********************************************************
   logic       pend_r;         // host write awaiting service
   logic [3:0] ofs_r;          // captured low address nibble
   logic       svc;            // servicing the write this cycle

   // receiver exit path services too, even with the event masked
   assign svc = pend_r & (irq_en_r | rx_handler_exit_in);

   // lockout holds from the write until the device releases it
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         pend_r <= 1'b0;
         ofs_r  <= 4'h0;
      end else if (wr_rise && !pend_r) begin
         pend_r <= 1'b1;
         ofs_r  <= wr_sync.addr[3:0];
      end else if (svc) begin
         pend_r <= 1'b0;
      end
   end

   assign host_lock_out               = pend_r;
   assign core_control_reg_pend_n_out = ~pend_r;

   // ***********************************************************
   // request flags
   // ***********************************************************
   logic cmd_flag_r;           // command request
   logic attn_flag_r;          // attention request
   logic attn_set;             // masked main status rise

   // host set wins over a completion in the same cycle
   always_ff @(posedge ref_clk_in) begin
      if (rst_in || init_now) begin
         cmd_flag_r <= 1'b0;
      end else if (svc && ofs_r == OFS_CMD) begin
         cmd_flag_r <= 1'b1;
      end else if (cmd_done_in) begin
         cmd_flag_r <= 1'b0;
      end
   end

   // status rise wins over a host clear in the same cycle
   always_ff @(posedge ref_clk_in) begin
      if (rst_in || init_now) begin
         attn_flag_r <= 1'b0;
      end else if (attn_set) begin
         attn_flag_r <= 1'b1;
      end else if (svc && ofs_r == OFS_FLAGS) begin
         attn_flag_r <= 1'b0;
      end
   end

   assign host_flags_out  = {attn_flag_r, cmd_flag_r, 6'h00};
   assign cmd_pending_out = cmd_flag_r;

   // ***********************************************************
   // command-loaded trigger and attention storage
   // ***********************************************************
   logic [7:0]  trig_mask_r;   // bits to compare
   logic [7:0]  trig_data_r;   // byte to match
   logic [15:0] trig_addr_r;   // screen address watched
   logic [7:0]  attn_mask_r;   // main bits that raise attention

   always_ff @(posedge ref_clk_in) begin
      if (rst_in || init_now) begin
         trig_mask_r <= BYTE_ZERO;
         trig_data_r <= BYTE_ZERO;
         trig_addr_r <= 16'h0000;
         attn_mask_r <= BYTE_ZERO;
      end else begin
         if (cmd_trig_dm_we_in) begin
            trig_mask_r <= cmd_arg_in[15:8];
            trig_data_r <= cmd_arg_in[7:0];
         end
         if (cmd_trig_addr_we_in) begin
            trig_addr_r <= cmd_arg_in;
         end
         if (cmd_attn_mask_we_in) begin
            attn_mask_r <= cmd_arg_in[7:0];
         end
      end
   end

   assign scr_addr_out = trig_addr_r;

   // ***********************************************************
   // periodic status update
   // ***********************************************************
   logic [7:0] tick_r;         // cycles to next update
   logic       upd;            // update strobe

   // free-running schedule, blind to host activity
   always_ff @(posedge ref_clk_in) begin
      if (rst_in || !task_run_out) begin
         tick_r <= STATUS_CYC_M1;
      end else if (tick_r == 8'h00) begin
         tick_r <= STATUS_CYC_M1;
      end else begin
         tick_r <= tick_r - 8'h01;
      end
   end

   assign upd = task_run_out & (tick_r == 8'h00);

   // ***********************************************************
   // status build
   // ***********************************************************
   logic [7:0] aux_new;        // freshly formed aux byte
   logic [7:0] main_new;       // freshly formed main byte
   logic [7:0] scr_prev_r;     // last sampled trigger byte
   logic       trig_hit;       // trigger condition this update

   assign aux_new = (line_main_status_word_in & AUX_KEEP)
                  | (line_control_word_in & AUX_KEEP);

   // zero mask turns the match into a change detector
   assign trig_hit = (trig_mask_r == BYTE_ZERO) ?
                     (scr_data_in != scr_prev_r) :
                     (((scr_data_in ^ trig_data_r)
                       & trig_mask_r) == BYTE_ZERO);

   // host clear acts first; new events then set over it
   always_comb begin
      main_new = status_out.main;
      if (cmd_clr_main_in) begin
         main_new = main_new & ~cmd_clr_bits_in;
      end
      main_new = main_new | (line_main_status_word_in & MS_STICKY);
      main_new[MS_CURSET] = main_new[MS_CURSET]
                          | line_main_status_word_in[MS_CURSET];
      if (aux_new != status_out.aux) begin
         main_new[MS_AUXCHG] = 1'b1;
      end
      if (trig_hit) begin
         main_new[MS_TRIG] = 1'b1;
      end
      main_new[MS_FATAL]  = 1'b0;
      main_new[MS_CMDIRQ] = 1'b0;
   end

   // previous aux kept in the output register until next update
   always_ff @(posedge ref_clk_in) begin
      if (rst_in || init_now) begin
         status_out <= '0;
         scr_prev_r <= BYTE_ZERO;
      end else if (upd) begin
         status_out.aux  <= aux_new;
         status_out.main <= main_new;
         scr_prev_r      <= scr_data_in;
      end else if (cmd_clr_main_in) begin
         status_out.main <= status_out.main & ~cmd_clr_bits_in;
      end
   end

   // attention on masked zero-to-one between successive updates
   assign attn_set = upd
                   & (|(main_new & ~status_out.main & attn_mask_r));

   // ***********************************************************
   // checks
   // ***********************************************************
   localparam int UPD_WIN = STATUS_CYC;

   property p_init_clear;
      @(posedge ref_clk_in) disable iff (rst_in)
      init_now |=> (host_flags_out == BYTE_ZERO) && attn_mask_r == 8'h00;
   endproperty
   a_init_clear: assert property (p_init_clear)
      else $error("init did not clear flags");

   property p_init_start;
      @(posedge ref_clk_in) disable iff (rst_in)
      init_now |=> irq_en_r && task_run_out && online_req_out;
   endproperty
   a_init_start: assert property (p_init_start)
      else $error("init did not start task");

   property p_flag_byte;
      @(posedge ref_clk_in) disable iff (rst_in)
      $rose(cmd_flag_r) |-> host_flags_out[FLG_CMD]
         && host_flags_out[5:0] == 6'h00;
   endproperty
   a_flag_byte: assert property (p_flag_byte)
      else $error("flag byte layout wrong");

   property p_lock;
      @(posedge ref_clk_in) disable iff (rst_in)
      wr_rise && !pend_r |=> host_lock_out;
   endproperty
   a_lock: assert property (p_lock)
      else $error("block write did not lock host");

   property p_cmd_set;
      @(posedge ref_clk_in) disable iff (rst_in)
      svc && ofs_r == OFS_CMD && !init_now |=> cmd_flag_r && !host_lock_out;
   endproperty
   a_cmd_set: assert property (p_cmd_set)
      else $error("226h write did not set command");

   property p_attn_clr;
      @(posedge ref_clk_in) disable iff (rst_in)
      svc && ofs_r == OFS_FLAGS && !attn_set |=> !attn_flag_r;
   endproperty
   a_attn_clr: assert property (p_attn_clr)
      else $error("227h write did not clear attention");

   property p_other;
      @(posedge ref_clk_in) disable iff (rst_in)
      svc && ofs_r != OFS_CMD && ofs_r != OFS_FLAGS && !cmd_done_in
         && !attn_set && !init_now
      |=> $stable(host_flags_out) && !host_lock_out;
   endproperty
   a_other: assert property (p_other)
      else $error("other write changed flags");

   property p_hold_lock;
      @(posedge ref_clk_in) disable iff (rst_in)
      host_lock_out && !svc |=> host_lock_out;
   endproperty
   a_hold_lock: assert property (p_hold_lock)
      else $error("lock released without service");

   property p_period;
      @(posedge ref_clk_in) disable iff (rst_in || !task_run_out)
      upd ##1 task_run_out |-> ##[1:UPD_WIN] upd;
   endproperty
   a_period: assert property (p_period)
      else $error("status update missed its period");

   property p_auxchg;
      @(posedge ref_clk_in) disable iff (rst_in)
      upd && aux_new != status_out.aux && !init_now
      |=> status_out.main[MS_AUXCHG];
   endproperty
   a_auxchg: assert property (p_auxchg)
      else $error("aux change not flagged");

   property p_zero_bits;
      @(posedge ref_clk_in) disable iff (rst_in)
      !status_out.main[MS_FATAL] && !status_out.main[MS_CMDIRQ];
   endproperty
   a_zero_bits: assert property (p_zero_bits)
      else $error("forced-zero main bit set");

   property p_attn_rise;
      @(posedge ref_clk_in) disable iff (rst_in)
      attn_set && !init_now |=> attn_flag_r && host_flags_out[FLG_ATTN];
   endproperty
   a_attn_rise: assert property (p_attn_rise)
      else $error("masked rise did not raise attention");

   property p_cv_cmd;
      @(posedge ref_clk_in) disable iff (rst_in)
      cmd_flag_r ##[1:20] !cmd_flag_r;
   endproperty
   c_cmd: cover property (p_cv_cmd);

   property p_cv_attn;
      @(posedge ref_clk_in) disable iff (rst_in)
      $rose(attn_flag_r);
   endproperty
   c_attn: cover property (p_cv_attn);

   property p_cv_fast;
      @(posedge ref_clk_in) disable iff (rst_in)
      svc && !irq_en_r;
   endproperty
   c_fast: cover property (p_cv_fast);

endmodule
`default_nettype wire

//--- common/hcf_pkg.sv
// Purpose: shared constants and types for the host command flag block
// Assumes: one 125 MHz core clock, host pins synchronised before use
// Notes:   flag byte and status layouts defined here; hcf_flags also packs the flag byte inline
package hcf_pkg;

   // ***********************************************************
   // timing
   // ***********************************************************
   localparam int CLK_PERIOD_NS    = 8;     // 125 MHz core clock
   localparam int STATUS_PERIOD_NS = 1000;  // status refresh period
   // longest time: round down, never below one cycle
   localparam int STATUS_CYC =
      (STATUS_PERIOD_NS / CLK_PERIOD_NS < 1) ? 1 :
      STATUS_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [7:0] STATUS_CYC_M1 = 8'(STATUS_CYC - 1);

   // ***********************************************************
   // host address decode
   // ***********************************************************
   localparam logic [5:0] BLK_BASE  = 6'h22;  // 220h..22Fh block
   localparam logic [3:0] OFS_CMD   = 4'h6;   // 226h sets command
   localparam logic [3:0] OFS_FLAGS = 4'h7;   // 227h clears attention

   // ***********************************************************
   // flag byte and status bit positions
   // ***********************************************************
   localparam int FLG_CMD    = 6;
   localparam int FLG_ATTN   = 7;
   localparam int MS_AUXCHG  = 7;
   localparam int MS_TRIG    = 6;
   localparam int MS_KEYEMP  = 5;
   localparam int MS_FATAL   = 4;
   localparam int MS_URESET  = 3;
   localparam int MS_CMDIRQ  = 2;
   localparam int MS_BUFMOD  = 1;
   localparam int MS_CURSET  = 0;
   // sticky main bits taken from the line word
   localparam logic [7:0] MS_STICKY = 8'h2A;
   // main bits ORed in from the line word and held until cleared
   localparam logic [7:0] MS_DIRECT = 8'h01;
   // aux: bit 7 unused, bits 6..0 kept
   localparam logic [7:0] AUX_KEEP  = 8'h7F;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   // ***********************************************************
   // types
   // ***********************************************************
   typedef enum logic [1:0] {
      HCF_OFF, HCF_INIT, HCF_RUN
   } hcf_mode_e;

   typedef struct packed {
      logic       stb;   // host write strobe
      logic [9:0] addr;  // host I/O address
   } hcf_hostwr_s;

   typedef struct packed {
      logic [7:0] main;  // main status byte
      logic [7:0] aux;   // auxiliary status byte
   } hcf_status_s;

endpackage

//--- verilog/hcf_sync.sv
// Purpose: two flip-flop synchroniser for host pin groups
// Assumes: each bit is a level; groups settle before the strobe rises
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
module hcf_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         ref_clk_in,
   input  wire logic         rst_in,
   // level in and out
   input  wire logic [W-1:0] d_in,
   output var  logic [W-1:0] q_out
);

   // ***********************************************************
   // per-bit double flop
   // ***********************************************************
   logic [W-1:0] meta_r;  // first stage, read by second only

   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         always_ff @(posedge ref_clk_in) begin
            if (rst_in) begin
               meta_r[g] <= 1'b0;
               q_out[g]  <= 1'b0;
            end else begin
               meta_r[g] <= d_in[g];
               q_out[g]  <= meta_r[g];
            end
         end
      end
   endgenerate

endmodule
`default_nettype wire

//--- test/hcf_host_model.sv
// Purpose: host processor model writing the 220h..22Fh block
// Assumes: lock output of the flag block is registered
// Notes:   a released bus shows the inverted address, never stale
`timescale 1ns/100ps
`default_nettype none
module hcf_host_model
   import hcf_pkg::*;
(
   // clock
   input  wire logic        ref_clk_in,
   // lock seen from the device
   input  wire logic        host_lock_in,
   // host write pins
   output hcf_hostwr_s      host_wr_out
);
   // ***********************************************************
   // write cycle
   // ***********************************************************
   initial host_wr_out = '{stb: 1'b0, addr: 10'h3FF};

   // hold the write until lock is seen or 12 cycles pass, then wait for the unlock
   task automatic wr(input logic [9:0] a, input bit exp_lock,
                     output bit ok);
      bit seen;
      seen = 1'b0;
      @(posedge ref_clk_in);
      host_wr_out <= '{stb: 1'b1, addr: a};
      for (int n = 0; n < 12 && !seen; n++) begin
         @(negedge ref_clk_in);
         seen = (host_lock_in === 1'b1);
      end
      ok = (seen == exp_lock);
      @(posedge ref_clk_in);
      // inverted address so a stale value cannot pass for valid
      host_wr_out <= '{stb: 1'b0, addr: ~a};
      // no new access until the device unlocks
      for (int n = 0; n < 12 && host_lock_in !== 1'b0; n++) begin
         @(negedge ref_clk_in);
      end
      if (host_lock_in !== 1'b0) begin
         ok = 1'b0;
      end
      // idle gap so the synchroniser sees the strobe low
      repeat (3) @(posedge ref_clk_in);
   endtask
endmodule
`default_nettype wire

//--- test/tb.sv
// Purpose: self-checking bench for the host command flag block
// Assumes: status refresh every STATUS_CYC cycles once running
// Notes:   line side and command engine are driven by the bench
`timescale 1ns/100ps
`default_nettype none
module tb;
   import hcf_pkg::*;
   // ***********************************************************
   // signals
   // ***********************************************************
   logic        clk, rst, mode_sel, alt_proto;
   logic [7:0]  line_ms, line_cw, scr_data, c_bits, flags;
   logic        c_done, c_clr, c_dm, c_ad, c_am;
   logic [15:0] c_arg, scr_addr;
   logic        lock, online, task_run, rx_exit, pend_cmd, pend_n;
   hcf_hostwr_s hw_pins;
   hcf_status_s st;
   int          fails, num_checks;

   hcf_flags u_hcf_flags (
      .ref_clk_in(clk), .rst_in(rst), .mode_sel_in(mode_sel),
      .alt_proto_in(alt_proto), .host_wr_in(hw_pins),
      .host_flags_out(flags), .host_lock_out(lock),
      .line_main_status_word_in(line_ms),
      .line_control_word_in(line_cw),
      .rx_handler_exit_in(rx_exit), .online_req_out(online),
      .scr_addr_out(scr_addr), .scr_data_in(scr_data),
      .cmd_done_in(c_done), .cmd_clr_main_in(c_clr),
      .cmd_clr_bits_in(c_bits), .cmd_trig_dm_we_in(c_dm),
      .cmd_trig_addr_we_in(c_ad), .cmd_attn_mask_we_in(c_am),
      .cmd_arg_in(c_arg), .cmd_pending_out(pend_cmd),
      .status_out(st), .core_control_reg_pend_n_out(pend_n),
      .task_run_out(task_run));

   hcf_host_model u_hcf_host_model (
      .ref_clk_in(clk), .host_lock_in(lock), .host_wr_out(hw_pins));

   // 125 MHz core clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ***********************************************************
   // shared tasks
   // ***********************************************************
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // one host write; a hang of the handshake ends the run
   task automatic hw(input logic [9:0] a, input bit exp_lock);
      bit ok;
      u_hcf_host_model.wr(a, exp_lock, ok);
      check({15'h0000, ok}, 16'h0001);
      if (!ok) begin
         close_out();
      end
   endtask

   // one-cycle command engine pulse: 0 done 1 clear 2 dm 3 addr 4 mask
   task automatic cmd(input int k, input logic [15:0] arg);
      @(posedge clk);
      c_arg  <= arg;
      c_bits <= arg[7:0];
      case (k)
         0: c_done <= 1'b1;
         1: c_clr <= 1'b1;
         2: c_dm <= 1'b1;
         3: c_ad <= 1'b1;
         default: c_am <= 1'b1;
      endcase
      @(posedge clk);
      {c_done, c_clr, c_dm, c_ad, c_am} <= 5'h00;
      @(negedge clk);
   endtask

   // at least one full status refresh has landed afterwards
   task automatic wait_upd;
      repeat (STATUS_CYC + 3) @(posedge clk);
      @(negedge clk);
   endtask

   // ***********************************************************
   // scenarios
   // ***********************************************************
   // masked write before mode entry, serviced from the receiver exit
   task automatic s_fast;
      fork
         hw(10'h226, 1'b1);
         begin
            repeat (4) @(posedge clk);
            @(negedge clk);
            check({14'h0000, lock, pend_n}, 16'h0002);
            @(posedge clk);
            rx_exit <= 1'b1;
            @(posedge clk);
            rx_exit <= 1'b0;
         end
      join
      check({8'h00, flags}, 16'h0040);
   endtask

   task automatic s_init;
      int pulses;
      pulses = 0;
      @(posedge clk);
      mode_sel  <= 1'b1;
      alt_proto <= 1'b1;
      // alternate protocol set: the mode must stay off
      repeat (10) @(negedge clk);
      check({14'h0000, task_run, online}, 16'h0000);
      @(posedge clk);
      alt_proto <= 1'b0;
      for (int n = 0; n < 20; n++) begin
         @(negedge clk);
         pulses += (online === 1'b1);
      end
      check({15'h0000, task_run}, 16'h0001);
      check(16'(pulses), 16'h0001);
      check({st.main, flags}, 16'h0000);
   endtask

   task automatic s_cmd;
      // command byte and arguments first, then the request
      for (int a = 0; a < 4; a++) begin
         hw(10'h220 + 10'(a), 1'b1);
      end
      check({8'h00, flags}, 16'h0000);
      hw(10'h226, 1'b1);
      check({8'h00, flags}, 16'h0040);
      check({15'h0000, pend_cmd}, 16'h0001);
      hw(10'h22F, 1'b1);
      check({8'h00, flags}, 16'h0040);
      hw(10'h300, 1'b0);
      check({8'h00, flags}, 16'h0040);
      cmd(0, 16'h0000);
      check({8'h00, flags}, 16'h0000);
      check({15'h0000, pend_cmd}, 16'h0000);
   endtask

   task automatic s_status;
      cmd(4, 16'h00FF);
      @(posedge clk);
      line_ms <= 8'h21;
      line_cw <= 8'h81;
      wait_upd();
      check(st, 16'hA121);
      check({8'h00, flags}, 16'h0080);
      @(posedge clk);
      line_ms <= 8'h00;
      wait_upd();
      check(st, 16'hA101);
      hw(10'h227, 1'b1);
      check({8'h00, flags}, 16'h0000);
      cmd(1, 16'h00FF);
      wait_upd();
      check(st, 16'h0001);
      check({8'h00, flags}, 16'h0000);
   endtask

   task automatic s_trig;
      cmd(3, 16'h1234);
      check(scr_addr, 16'h1234);
      @(posedge clk);
      scr_data <= 8'h5A;
      wait_upd();
      check(st, 16'h4001);
      check({8'h00, flags}, 16'h0080);
      hw(10'h227, 1'b1);
      cmd(2, 16'hF0A5);
      cmd(1, 16'h00FF);
      wait_upd();
      check(st, 16'h0001);
      cmd(2, 16'hF05F);
      wait_upd();
      check(st, 16'h4001);
   endtask

   // ***********************************************************
   // main sequence
   // ***********************************************************
   initial begin
      fails = 0;
      num_checks = 0;
      rst <= 1'b1;
      {mode_sel, alt_proto, line_ms, line_cw, scr_data} <= 26'h0;
      {c_done, c_clr, c_dm, c_ad, c_am, c_arg, c_bits} <= 29'h0;
      rx_exit <= 1'b0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      check({7'h00, lock, flags}, 16'h0000);
      s_fast();
      s_init();
      s_cmd();
      s_status();
      s_trig();
      close_out();
   end
endmodule
`default_nettype wire
